/* verilog/cmpcs_pkg.sv */
// cmpcs_pkg: offsets, field positions and reset values of the comparator register bank
// assumes: 32-bit apb, byte addresses, alias offsets +4/+8/+C from each base
package cmpcs_pkg;

  // ---------------------------------------------------------------
  // register bases (word aligned), alias offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CMPCS_CTRL1_OFS  = 8'h00;
  localparam logic [7:0] CMPCS_CTRL2_OFS  = 8'h10;
  localparam logic [7:0] CMPCS_STAT_OFS   = 8'h20;
  localparam logic [7:0] CMPCS_IFLAG_OFS  = 8'h30;
  localparam logic [7:0] CMPCS_IEN_OFS    = 8'h40;
  localparam logic [7:0] CMPCS_IPRI_OFS   = 8'h50;
  localparam logic [1:0] CMPCS_ALIAS_PLAIN = 2'h0;
  localparam logic [1:0] CMPCS_ALIAS_CLR   = 2'h1;
  localparam logic [1:0] CMPCS_ALIAS_SET   = 2'h2;
  localparam logic [1:0] CMPCS_ALIAS_INV   = 2'h3;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int CMPCS_CTRL_ON   = 15;
  localparam int CMPCS_CTRL_OE   = 14;
  localparam int CMPCS_CTRL_POL  = 13;
  localparam int CMPCS_CTRL_RES  = 8;
  localparam int CMPCS_CTRL_EDGE = 6;
  localparam int CMPCS_CTRL_PSEL = 4;
  localparam int CMPCS_CTRL_NSEL = 0;
  // writable bits of control
  localparam logic [31:0] CMPCS_CTRL_WMASK = 32'h0000_E0D3;
  localparam logic [31:0] CMPCS_CTRL_RST   = 32'h0000_00C3;

  // ---------------------------------------------------------------
  // status register fields
  // ---------------------------------------------------------------
  localparam int CMPCS_STAT_FRZ  = 14;
  localparam int CMPCS_STAT_STOP_IN_IDLE = 13;
  localparam logic [31:0] CMPCS_STAT_WMASK = 32'h0000_6000;
  localparam logic [31:0] CMPCS_STAT_RST   = 32'h0000_0000;

  // ---------------------------------------------------------------
  // interrupt registers
  // ---------------------------------------------------------------
  localparam int CMPCS_IRQ_BIT1 = 3;
  localparam int CMPCS_IRQ_BIT2 = 4;
  localparam logic [31:0] CMPCS_IRQ_WMASK  = 32'h0000_0018;
  localparam logic [31:0] CMPCS_IPRI_WMASK = 32'h001F_1F00;
  localparam logic [31:0] CMPCS_IRQ_RST    = 32'h0000_0000;
  localparam int CMPCS_IPRI_LSB1 = 8;
  localparam int CMPCS_IPRI_LSB2 = 16;

  // ---------------------------------------------------------------
  // edge select and negative input codes
  // ---------------------------------------------------------------
  localparam logic [1:0] CMPCS_EDGE_NONE = 2'h0;
  localparam logic [1:0] CMPCS_EDGE_RISE = 2'h1;
  localparam logic [1:0] CMPCS_EDGE_FALL = 2'h2;
  localparam logic [1:0] CMPCS_EDGE_BOTH = 2'h3;
  localparam logic [1:0] CMPCS_NSEL_NEG1 = 2'h0;
  localparam logic [1:0] CMPCS_NSEL_POS1 = 2'h1;
  localparam logic [1:0] CMPCS_NSEL_POS2 = 2'h2;
  localparam logic [1:0] CMPCS_NSEL_ABS  = 2'h3;

endpackage : cmpcs_pkg

/* verilog/cmpcs_chan.sv */
// cmpcs_chan: one comparator result path: synchroniser, polarity, edge event
// assumes: raw_i is asynchronous from the analog core
`timescale 1ns/10ps
module cmpcs_chan (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  // control
  input  wire logic       enable_i,
  input  wire logic       invert_i,
  input  wire logic [1:0] edge_sel_i,
  // analog side
  input  wire logic       raw_i,
  // results
  output logic            result_o,
  output logic            event_o
);

  logic sync_a;
  logic sync_b;
  logic prev;
  logic pol;

  // ----------------------------------------------------------------
  // two-stage synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= raw_i;
      sync_b <= sync_a;
    end
  end

  assign pol = (sync_b ^ invert_i) & enable_i;

  // ----------------------------------------------------------------
  // edge detection on the polarity-corrected result
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev    <= 1'b0;
      event_o <= 1'b0;
    end else begin
      prev <= pol;
      case (edge_sel_i)
        cmpcs_pkg::CMPCS_EDGE_RISE: event_o <= pol & ~prev;
        cmpcs_pkg::CMPCS_EDGE_FALL: event_o <= ~pol & prev;
        cmpcs_pkg::CMPCS_EDGE_BOTH: event_o <= pol ^ prev;
        default:                    event_o <= 1'b0;
      endcase
    end
  end

  assign result_o = pol;

endmodule : cmpcs_chan

/* verilog/cmpcs_top.sv */
// cmpcs_top: apb register bank for two comparators and their interrupt bits
// assumes: apb master on clock_i; analog core takes enables and selects as levels
// How it works
// - two comparator instances, each with its own control register
// - each control register has clear, set and invert write aliases
// - shared status register has clear, set and invert aliases too
// - alias writes act only on written ones of writable bits
// - status shows results in bits 1:0, freeze 14, idle stop 13
// - enable bit 15 turns comparator on, other bits kept
// - bit 14 drives the result onto the output pin
// - bit 13 inverts result for pin, status and edge detection
// - result copy bit 8, edge select 7:6, positive 4, negative 1:0
// - positive select: 1 voltage reference, 0 own positive pin
// - negative select: 11 absolute ref, 10 pos2, 01 pos1, 00 neg1
// - interrupt flags at bits 3 and 4, with aliases
// - interrupt enables at bits 3 and 4, with aliases
// - priority 3 bits and subpriority 2 bits at 12:8 and 20:16
// - inputs choose among pins, absolute and programmable references
`timescale 1ns/10ps
module cmpcs_top (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // analog core
  input  wire logic [1:0]  raw_result_i,
  output logic [1:0]       cmp_enable_o,
  output logic [1:0]       positive_input_select_o,
  output logic [3:0]       negative_input_select_o,
  // output pins
  output logic [1:0]       result_pin_o,
  output logic [1:0]       result_pin_oe_o,
  // power and debug controls
  output logic             freeze_in_debug_o,
  output logic             stop_in_idle_o,
  // interrupt
  output logic             irq_o
);

  logic [31:0] ctrl [2];
  logic [31:0] stat_r;
  logic [31:0] iflag;
  logic [31:0] ien;
  logic [31:0] ipri;
  logic [1:0]  result;
  logic [1:0]  event_p;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] next_prdata;
  logic        next_err;
  logic [31:0] irq_evt;

  // ----------------------------------------------------------------
  // alias decode, used by every register
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
    hit = (a[7:4] == base[7:4]) && (a[1:0] == 2'h0);
  endfunction : hit

  function automatic logic [31:0] apply(input logic [31:0] cur,
                                        input logic [31:0] wd,
                                        input logic [1:0]  alias_sel,
                                        input logic [31:0] wmask);
    logic [31:0] nv;
    nv = cur;
    case (alias_sel)
      cmpcs_pkg::CMPCS_ALIAS_PLAIN: nv = wd;
      cmpcs_pkg::CMPCS_ALIAS_CLR:   nv = cur & ~wd;
      cmpcs_pkg::CMPCS_ALIAS_SET:   nv = cur | wd;
      cmpcs_pkg::CMPCS_ALIAS_INV:   nv = cur ^ wd;
      default:                      nv = cur;
    endcase
    apply = (nv & wmask) | (cur & ~wmask);
  endfunction : apply

  assign wr_en = psel_i & penable_i & pwrite_i & pready_o;
  assign rd_en = psel_i & penable_i & ~pwrite_i & pready_o;

  // ----------------------------------------------------------------
  // per comparator control and result path
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_cmp
      localparam logic [7:0] BASE = (g == 0) ? cmpcs_pkg::CMPCS_CTRL1_OFS
                                             : cmpcs_pkg::CMPCS_CTRL2_OFS;

      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          ctrl[g] <= cmpcs_pkg::CMPCS_CTRL_RST;
        end else if (wr_en && hit(paddr_i, BASE)) begin
          ctrl[g] <= apply(ctrl[g], pwdata_i, paddr_i[3:2],
                           cmpcs_pkg::CMPCS_CTRL_WMASK);
        end
      end

      cmpcs_chan u_chan (
        .clock_i    (clock_i),
        .rst_b_i    (rst_b_i),
        .enable_i   (ctrl[g][cmpcs_pkg::CMPCS_CTRL_ON]),
        .invert_i   (ctrl[g][cmpcs_pkg::CMPCS_CTRL_POL]),
        .edge_sel_i (ctrl[g][cmpcs_pkg::CMPCS_CTRL_EDGE +: 2]),
        .raw_i      (raw_result_i[g]),
        .result_o   (result[g]),
        .event_o    (event_p[g])
      );

      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          cmp_enable_o[g]                 <= 1'b0;
          positive_input_select_o[g]      <= 1'b0;
          // follows the control reset value, no step after reset
          negative_input_select_o[2*g +: 2] <=
            cmpcs_pkg::CMPCS_CTRL_RST[cmpcs_pkg::CMPCS_CTRL_NSEL +: 2];
          result_pin_o[g]                 <= 1'b0;
          result_pin_oe_o[g]              <= 1'b0;
        end else begin
          cmp_enable_o[g] <= ctrl[g][cmpcs_pkg::CMPCS_CTRL_ON];
          positive_input_select_o[g] <= ctrl[g][cmpcs_pkg::CMPCS_CTRL_PSEL];
          negative_input_select_o[2*g +: 2] <=
            ctrl[g][cmpcs_pkg::CMPCS_CTRL_NSEL +: 2];
          result_pin_o[g]    <= result[g] & ctrl[g][cmpcs_pkg::CMPCS_CTRL_OE];
          result_pin_oe_o[g] <= ctrl[g][cmpcs_pkg::CMPCS_CTRL_OE]
                                & ctrl[g][cmpcs_pkg::CMPCS_CTRL_ON];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // shared status register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stat_r <= cmpcs_pkg::CMPCS_STAT_RST;
    end else if (wr_en && hit(paddr_i, cmpcs_pkg::CMPCS_STAT_OFS)) begin
      stat_r <= apply(stat_r, pwdata_i, paddr_i[3:2],
                      cmpcs_pkg::CMPCS_STAT_WMASK);
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      freeze_in_debug_o <= 1'b0;
      stop_in_idle_o    <= 1'b0;
    end else begin
      freeze_in_debug_o <= stat_r[cmpcs_pkg::CMPCS_STAT_FRZ];
      stop_in_idle_o    <= stat_r[cmpcs_pkg::CMPCS_STAT_STOP_IN_IDLE];
    end
  end

  // ----------------------------------------------------------------
  // interrupt flags, enables and priorities
  // ----------------------------------------------------------------
  always_comb begin
    irq_evt = 32'h0000_0000;
    irq_evt[cmpcs_pkg::CMPCS_IRQ_BIT1] = event_p[0];
    irq_evt[cmpcs_pkg::CMPCS_IRQ_BIT2] = event_p[1];
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      iflag <= cmpcs_pkg::CMPCS_IRQ_RST;
    end else if (wr_en && hit(paddr_i, cmpcs_pkg::CMPCS_IFLAG_OFS)) begin
      iflag <= apply(iflag, pwdata_i, paddr_i[3:2],
                     cmpcs_pkg::CMPCS_IRQ_WMASK) | irq_evt;
    end else if (rd_en && hit(paddr_i, cmpcs_pkg::CMPCS_IFLAG_OFS)
                 && paddr_i[3:2] == cmpcs_pkg::CMPCS_ALIAS_PLAIN) begin
      // read clears only the bits it reported, later events survive
      iflag <= (iflag & ~prdata_o) | irq_evt;
    end else begin
      iflag <= iflag | irq_evt;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ien <= cmpcs_pkg::CMPCS_IRQ_RST;
    end else if (wr_en && hit(paddr_i, cmpcs_pkg::CMPCS_IEN_OFS)) begin
      ien <= apply(ien, pwdata_i, paddr_i[3:2], cmpcs_pkg::CMPCS_IRQ_WMASK);
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ipri <= cmpcs_pkg::CMPCS_IRQ_RST;
    end else if (wr_en && hit(paddr_i, cmpcs_pkg::CMPCS_IPRI_OFS)) begin
      ipri <= apply(ipri, pwdata_i, paddr_i[3:2], cmpcs_pkg::CMPCS_IPRI_WMASK);
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(iflag & ien & cmpcs_pkg::CMPCS_IRQ_WMASK);
    end
  end

  // ----------------------------------------------------------------
  // apb read mux and answer
  // ----------------------------------------------------------------
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_err    = 1'b0;
    if (paddr_i[3:2] == cmpcs_pkg::CMPCS_ALIAS_PLAIN && paddr_i[1:0] == 2'h0) begin
      case (paddr_i[7:4])
        cmpcs_pkg::CMPCS_CTRL1_OFS[7:4]: begin
          next_prdata = ctrl[0] & cmpcs_pkg::CMPCS_CTRL_WMASK;
          next_prdata[cmpcs_pkg::CMPCS_CTRL_RES] = result[0];
        end
        cmpcs_pkg::CMPCS_CTRL2_OFS[7:4]: begin
          next_prdata = ctrl[1] & cmpcs_pkg::CMPCS_CTRL_WMASK;
          next_prdata[cmpcs_pkg::CMPCS_CTRL_RES] = result[1];
        end
        cmpcs_pkg::CMPCS_STAT_OFS[7:4]: begin
          next_prdata = stat_r & cmpcs_pkg::CMPCS_STAT_WMASK;
          next_prdata[1:0] = result;
        end
        cmpcs_pkg::CMPCS_IFLAG_OFS[7:4]: next_prdata = iflag;
        cmpcs_pkg::CMPCS_IEN_OFS[7:4]:   next_prdata = ien;
        cmpcs_pkg::CMPCS_IPRI_OFS[7:4]:  next_prdata = ipri;
        default:                         next_err = 1'b1;
      endcase
    end else if (paddr_i[1:0] != 2'h0 || paddr_i[7:4] > cmpcs_pkg::CMPCS_IPRI_OFS[7:4]) begin
      next_err = 1'b1;
    end
    // alias reads return zero
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (psel_i && penable_i && !pready_o) begin
      pready_o  <= 1'b1;
      prdata_o  <= pwrite_i ? 32'h0000_0000 : next_prdata;
      pslverr_o <= next_err;
    end else begin
      pready_o  <= 1'b0;
      prdata_o  <= rd_en ? prdata_o : 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
  end

endmodule : cmpcs_top

/* sim/cmpcs_props.sv */
// cmpcs_props: port-level assertions for the comparator register bank
// assumes: bound to cmpcs_top, one clock domain, async active-low reset
`timescale 1ns/10ps
module cmpcs_props (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  // apb
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] prdata_o,
  input  wire logic        pready_o,
  input  wire logic        pslverr_o,
  // comparator side
  input  wire logic [1:0]  raw_result_i,
  input  wire logic [1:0]  cmp_enable_o,
  input  wire logic [1:0]  positive_input_select_o,
  input  wire logic [3:0]  negative_input_select_o,
  input  wire logic [1:0]  result_pin_o,
  input  wire logic [1:0]  result_pin_oe_o,
  input  wire logic        freeze_in_debug_o,
  input  wire logic        stop_in_idle_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  sequence acc_start;
    psel_i && penable_i && !$past(penable_i);
  endsequence
  sequence raw0_moved;
    $changed(raw_result_i[0]) && $stable(cmp_enable_o[0]) && result_pin_oe_o[0]
      && !pready_o && $past(raw_result_i[0]) == $past(raw_result_i[0], 2);
  endsequence
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  ready_wait_a: assert property (acc_start |-> !pready_o ##1 pready_o)
    else $error("answer not in second access cycle");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  err_zero_a: assert property (pready_o && pslverr_o |-> prdata_o == 32'h0)
    else $error("refused access returned data");
  oe_needs_en_a: assert property ((result_pin_oe_o & ~cmp_enable_o) == 2'h0)
    else $error("pin driven by disabled comparator");
  pin_gated_a: assert property ((result_pin_o & ~result_pin_oe_o) == 2'h0)
    else $error("pin high while not driven");
  sync_delay_a: assert property (raw0_moved |=> $stable(result_pin_o[0]))
    else $error("raw result reached pin too early");
  ctl_by_write_a: assert property ($changed({cmp_enable_o, positive_input_select_o,
      negative_input_select_o, freeze_in_debug_o, stop_in_idle_o})
      |-> $past(pready_o && pwrite_i) || $past(pready_o && pwrite_i, 2))
    else $error("control output moved without a write");
endmodule : cmpcs_props

/* sim/cmpcs_core_model.sv */
// cmpcs_core_model: behavioural analog comparator core with input muxes
// assumes: levels are unsigned codes, larger means higher voltage
`timescale 1ns/10ps
module cmpcs_core_model (
  // control from the bank
  input  wire logic [1:0] enable_i,
  input  wire logic [1:0] positive_input_select_i,
  input  wire logic [3:0] negative_input_select_i,
  // analog levels
  input  wire logic [7:0] first_positive_pin_i,
  input  wire logic [7:0] first_negative_pin_i,
  input  wire logic [7:0] second_positive_pin_i,
  input  wire logic [7:0] absolute_internal_reference_i,
  input  wire logic [7:0] programmable_voltage_reference_i,
  // results
  output logic      [1:0] raw_result_o
);
  logic [7:0] pos [2];
  logic [7:0] neg [2];
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      pos[c] = c == 0 ? first_positive_pin_i : second_positive_pin_i;
      if (positive_input_select_i[c]) pos[c] = programmable_voltage_reference_i;
      case (negative_input_select_i[2*c +: 2])
        2'h3: neg[c] = absolute_internal_reference_i;
        2'h2: neg[c] = second_positive_pin_i;
        2'h1: neg[c] = first_positive_pin_i;
        default: neg[c] = first_negative_pin_i;
      endcase
      raw_result_o[c] = enable_i[c] && pos[c] > neg[c];
    end
  end
endmodule : cmpcs_core_model

/* sim/testbench.sv */
// testbench: register, pin and interrupt checks of cmpcs_top against a model
// assumes: cmpcs_pkg compiled first; core model drives the raw results
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
  $display("ERROR %0t mismatch %h vs %h", $time, (a), (e)); end end
module testbench;
  logic clock_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o, err, nr;
  logic freeze_in_debug_o, stop_in_idle_o;
  logic [7:0] paddr_i, vp1, vn1, vp2, vabs, vref;
  logic [31:0] pwdata_i, prdata_o, rd, d;
  logic [1:0] raw_result_i, cmp_enable_o, positive_input_select_o, result_pin_o, res;
  logic [1:0] result_pin_oe_o;
  logic [3:0] negative_input_select_o;
  logic [31:0] m [6];
  int errors, n_checks, seed, i, j, k, r, a;
  cmpcs_top dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .raw_result_i(raw_result_i), .cmp_enable_o(cmp_enable_o),
    .positive_input_select_o(positive_input_select_o),
    .negative_input_select_o(negative_input_select_o), .result_pin_o(result_pin_o),
    .result_pin_oe_o(result_pin_oe_o), .freeze_in_debug_o(freeze_in_debug_o),
    .stop_in_idle_o(stop_in_idle_o), .irq_o(irq_o));
  cmpcs_core_model core (.enable_i(cmp_enable_o), .positive_input_select_i(positive_input_select_o),
    .negative_input_select_i(negative_input_select_o), .first_positive_pin_i(vp1),
    .first_negative_pin_i(vn1), .second_positive_pin_i(vp2),
    .absolute_internal_reference_i(vabs), .programmable_voltage_reference_i(vref),
    .raw_result_o(raw_result_i));
  function automatic logic [31:0] wmask(int r);
    return r < 2 ? cmpcs_pkg::CMPCS_CTRL_WMASK : r == 2 ? cmpcs_pkg::CMPCS_STAT_WMASK :
      r == 5 ? cmpcs_pkg::CMPCS_IPRI_WMASK : cmpcs_pkg::CMPCS_IRQ_WMASK;
  endfunction : wmask
  task automatic give_verdict();
    if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int t;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= ad;
    pwdata_i <= wd;
    @(posedge clock_i);
    penable_i <= 1'b1;
    t = 0;
    do begin @(posedge clock_i); t++; end while (pready_o !== 1'b1 && t < 20);
    if (t >= 20) begin errors++; give_verdict(); end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    // idle edge keeps two transfers apart
    @(posedge clock_i);
  endtask : apb
  task automatic acc(input int r, input int a, input logic [31:0] wd, input logic wr);
    logic [31:0] e;
    apb(wr, 8'(r * 16 + a * 4), wd);
    `CHK(err, 1'b0)
    e = wd & wmask(r);
    if (wr) case (a)
      0: m[r] = e | (m[r] & ~wmask(r));
      1: m[r] = m[r] & ~e;
      2: m[r] = m[r] | e;
      default: m[r] = m[r] ^ e;
    endcase
    else begin
      e = a != 0 ? 32'h0 : r < 2 ? m[r] | {res[r], 8'h00} : r == 2 ? m[2] | res : m[r];
      `CHK(rd, e)
      // a plain read of the flags clears what it returned
      if (r == 3 && a == 0) m[3] = 32'h0;
    end
  endtask : acc
  task automatic chk_outs();
    // outputs follow registers one edge late
    @(posedge clock_i);
    `CHK(cmp_enable_o, {m[1][15], m[0][15]})
    `CHK(positive_input_select_o, {m[1][4], m[0][4]})
    `CHK(negative_input_select_o, {m[1][1:0], m[0][1:0]})
    `CHK(result_pin_oe_o, {m[1][14] & m[1][15], m[0][14] & m[0][15]})
    `CHK(result_pin_o, res & {m[1][14] & m[1][15], m[0][14] & m[0][15]})
    `CHK({freeze_in_debug_o, stop_in_idle_o}, m[2][14:13])
    `CHK(irq_o, |(m[3] & m[4] & 32'h18))
  endtask : chk_outs
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, rst_b_i, res} = '0;
    {vp1, vn1, vp2, vabs, vref} = {8'h00, 8'h80, 8'h00, 8'h80, 8'h80};
    seed = 77363;
    for (i = 0; i < 6; i++) m[i] = i < 2 ? 32'h0000_00C3 : 32'h0;
    repeat (4) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    apb(1'b1, 8'h60, 32'hFFFF_FFFF);
    `CHK(err, 1'b1)
    apb(1'b0, 8'hFC, 32'h0);
    `CHK({err, rd}, 33'h1_0000_0000)
    for (i = 0; i < 24; i++) acc(i / 4, i % 4, 0, 1'b0);
    chk_outs();
    // enable and polarity kept low so results stay quiet
    for (k = 0; k < 60; k++) begin
      r = $unsigned($random(seed)) % 6;
      a = $unsigned($random(seed)) % 4;
      d = $random(seed);
      if (r < 2) d = d & ~32'hA000;
      acc(r, a, d, 1'b1);
      acc(r, 0, 0, 1'b0);
      chk_outs();
    end
    acc(4, 0, 32'h18, 1'b1);
    for (i = 0; i < 2; i++) for (j = 0; j < 8; j++) begin
      acc(i, 0, 32'hC000 | {j[0], 13'h0}, 1'b1);
      repeat (8) @(posedge clock_i);
      res[i] = j[0];
      acc(3, 1, 32'h18, 1'b1);
      acc(i, 0, 32'hC000 | {j[0], 13'h0} | {j[2:1], 6'h00}, 1'b1);
      for (k = 0; k < 2; k++) begin
        if (i) vp2 <= k ? 8'h00 : 8'hF0;
        else vp1 <= k ? 8'h00 : 8'hF0;
        repeat (8) @(posedge clock_i);
        nr = !k ^ j[0];
        if (j[2:1] == 3 || (j[2:1] == 1 && nr) || (j[2:1] == 2 && !nr)) m[3][3 + i] = 1'b1;
        res[i] = nr;
        acc(i, 0, 0, 1'b0);
        chk_outs();
        acc(3, 0, 0, 1'b0);
        acc(2, 0, 0, 1'b0);
      end
    end
    acc(0, 0, 32'h8000, 1'b1);
    {vp1, vn1, vabs, vref} <= {8'h40, 8'h30, 8'h60, 8'h70};
    for (j = 0; j < 8; j++) begin
      acc(0, 0, 32'h8000 | {j[2], 4'h0} | j[1:0], 1'b1);
      repeat (8) @(posedge clock_i);
      res[0] = j[2] | !j[0];
      acc(2, 0, 0, 1'b0);
      chk_outs();
    end
    give_verdict();
  end
endmodule : testbench
bind cmpcs_top cmpcs_props u_props (.clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .raw_result_i(raw_result_i), .cmp_enable_o(cmp_enable_o),
  .positive_input_select_o(positive_input_select_o),
  .negative_input_select_o(negative_input_select_o), .result_pin_o(result_pin_o),
  .result_pin_oe_o(result_pin_oe_o), .freeze_in_debug_o(freeze_in_debug_o),
  .stop_in_idle_o(stop_in_idle_o));
